// >>> rbc_defines.svh
// Purpose: Constants for the nibble-bus real-time clock core
// Assumes: 4-bit address and data, 32.768 kHz crystal sampled on clk_sys
// Notes:   Offsets are nibble addresses on the host bus
`ifndef RBC_DEFINES_SVH
`define RBC_DEFINES_SVH
`define RBC_XTAL_DIV      32768
`define RBC_DIV_W         15
`define RBC_BIT_16HZ      10
`define RBC_BIT_1HZ       14
`define RBC_CNT_LAST      4'hC
`define RBC_ADDR_MODE     4'hD
`define RBC_ADDR_TEST     4'hE
`define RBC_ADDR_CTRL     4'hF
`define RBC_ADDR_SEL24    4'hA
`define RBC_ADDR_LEAP     4'hB
`define RBC_RAM_BANK      13
`define RBC_RAM_DEPTH     26
`define RBC_MODE_TIMER_EN 3
`define RBC_MODE_ALARM_EN 2
`define RBC_CTRL_1HZ      3
`define RBC_CTRL_16HZ     2
`define RBC_CTRL_TMR_RST  1
`define RBC_CTRL_ALM_RST  0
`define RBC_PM_BIT        1
`define RBC_MODE_RESET    4'h8
`endif

// >>> rbc_pkg.sv
// Purpose: Types for the nibble-bus real-time clock core
// Assumes: Used with rbc_defines.svh
// Notes:   Pin bundle is synchronised as one struct
package rbc_pkg;
  typedef struct packed {
    logic       selHigh;
    logic       selLowN;
    logic       rdN;
    logic       wrN;
    logic [3:0] addr;
    logic [3:0] data;
    logic       adjust;
    logic       crystal;
  } rbc_pins_t;
  typedef struct packed {
    logic       cntEn;
    logic       leapEn;
    logic [3:0] addr;
    logic [3:0] data;
  } rbc_wr_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_WRITE} rbc_bus_t;
endpackage

// >>> rbc_counter_chain.sv
// Purpose: BCD time and calendar counters with carries
// Assumes: One-cycle tick and adjust pulses from the core
// Notes:   Host writes win over counting in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "rbc_defines.svh"
module rbc_counter_chain
  import rbc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             clkEn,
  // Events
  input  wire logic             secTick,
  input  wire logic             adjPulse,
  input  wire logic             mode24,
  input  var  rbc_wr_t          wr,
  // State
  output logic [12:0][3:0]      cnt,
  output logic [1:0]            leap
);
  logic [12:0][3:0] next_cnt;
  logic [1:0]       next_leap;

  function automatic int monthDays(input int m, input logic isLeap);
    case (m)
      2:       monthDays = isLeap ? 29 : 28;
      4, 6, 9, 11: monthDays = 30;
      default: monthDays = 31;
    endcase
  endfunction

  always_comb begin
    int sec;
    int mn;
    int hr;
    int dow;
    int dy;
    int mo;
    int yr;
    logic pm;
    logic carry;
    sec = 10 * int'(cnt[1]) + int'(cnt[0]);
    mn = 10 * int'(cnt[3]) + int'(cnt[2]);
    pm = cnt[5][`RBC_PM_BIT];
    hr = mode24 ? 10 * int'(cnt[5][1:0]) + int'(cnt[4]) : 10 * int'(cnt[5][0]) + int'(cnt[4]);
    dow = int'(cnt[6]);
    dy = 10 * int'(cnt[8]) + int'(cnt[7]);
    mo = 10 * int'(cnt[10]) + int'(cnt[9]);
    yr = 10 * int'(cnt[12]) + int'(cnt[11]);
    carry = 1'b0;
    next_cnt = cnt;
    next_leap = leap;
    if (wr.cntEn) begin
      next_cnt[wr.addr] = wr.data;
    end else if (wr.leapEn) begin
      next_leap = wr.data[1:0];
    end else if (adjPulse || secTick) begin
      if (adjPulse) begin
        carry = (sec >= 30);
        sec = 0;
      end else begin
        sec = sec + 1;
        carry = (sec >= 60);
        if (carry) sec = 0;
      end
      if (carry) begin
        mn = mn + 1;
        carry = (mn >= 60);
        if (carry) mn = 0;
      end
      if (carry) begin
        if (mode24) begin
          hr = hr + 1;
          carry = (hr >= 24);
          if (carry) hr = 0;
        end else if (hr == 11) begin
          hr = 12;
          carry = pm;
          pm = ~pm;
        end else begin
          hr = (hr == 12) ? 1 : hr + 1;
          carry = 1'b0;
        end
      end
      if (carry) begin
        dow = (dow >= 6) ? 0 : dow + 1;
        dy = dy + 1;
        carry = (dy > monthDays(mo, leap == 2'd0));
        if (carry) dy = 1;
      end
      if (carry) begin
        mo = mo + 1;
        carry = (mo > 12);
        if (carry) mo = 1;
      end
      if (carry) begin
        yr = yr + 1;
        next_leap = leap + 2'd1;
        if (yr >= 100) yr = 0;
      end
      next_cnt[0] = 4'(sec % 10);
      next_cnt[1] = 4'(sec / 10);
      next_cnt[2] = 4'(mn % 10);
      next_cnt[3] = 4'(mn / 10);
      next_cnt[4] = 4'(hr % 10);
      next_cnt[5] = mode24 ? 4'(hr / 10) : {2'b00, pm, 1'(hr / 10)};
      next_cnt[6] = 4'(dow);
      next_cnt[7] = 4'(dy % 10);
      next_cnt[8] = 4'(dy / 10);
      next_cnt[9] = 4'(mo % 10);
      next_cnt[10] = 4'(mo / 10);
      next_cnt[11] = 4'(yr % 10);
      next_cnt[12] = 4'(yr / 10);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      leap <= 2'b00;
    end else if (clkEn) begin
      cnt <= next_cnt;
      leap <= next_leap;
    end
  end
endmodule // rbc_counter_chain
`default_nettype wire

// >>> rbc_core.sv
// Purpose: Nibble-bus real-time clock with alarm, pulse output and RAM
// Assumes: All pins are asynchronous to clk_sys and pass a two-stage sync
// Notes:   Crystal is oversampled; clk_sys must be far above 32.768 kHz
`timescale 1ns/1ps
`default_nettype none
`include "rbc_defines.svh"
module rbc_core
  import rbc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clkEn,
  // Host bus
  input  wire logic       selHigh,
  input  wire logic       selLowN,
  input  wire logic       rdN,
  input  wire logic       wrN,
  input  wire logic [3:0] nibbleAddress,
  input  wire logic [3:0] nibbleDataIn,
  output logic      [3:0] nibbleDataOut,
  output logic            nibbleDataOe,
  // Adjust and crystal
  input  wire logic       secondsRoundInput,
  input  wire logic       crystalInput,
  output logic            crystalOutput,
  // Open-drain alarm, low when enabled
  output logic            alarmOut,
  output logic            alarmOe
);
  rbc_pins_t pinsMeta;
  rbc_pins_t pins;
  rbc_pins_t pinsPrev;

  logic [12:0][3:0]     cnt;
  logic [1:0]           leap;
  logic [12:0][3:0]     alarmReg;
  logic [`RBC_RAM_DEPTH-1:0][3:0] ram;
  logic [3:0]           modeReg;
  logic [3:0]           testReg;
  logic [1:0]           pulseOn;
  logic                 sel24;
  logic                 alarmFlag;
  logic [`RBC_DIV_W-1:0] divCnt;
  logic                 secTick;
  logic                 adjPulse;
  rbc_bus_t             busState;
  logic [3:0]           holdAddr;
  logic [3:0]           holdData;
  rbc_wr_t              wrCnt;

  logic [3:0]           next_modeReg;
  logic [3:0]           next_testReg;
  logic [1:0]           next_pulseOn;
  logic                 next_sel24;
  logic                 next_alarmFlag;
  logic [`RBC_DIV_W-1:0] next_divCnt;
  logic                 next_secTick;
  logic                 next_adjPulse;
  rbc_bus_t             next_busState;
  logic [3:0]           next_holdAddr;
  logic [3:0]           next_holdData;
  logic [12:0][3:0]     next_alarmReg;
  logic [`RBC_RAM_DEPTH-1:0][3:0] next_ram;
  logic [3:0]           next_dataOut;
  logic                 next_dataOe;
  logic                 next_alarmOe;
  logic                 selected;
  logic                 wrCommit;

  // Bits that always read zero in the counter bank
  function automatic logic [3:0] cntMask(input logic [3:0] a);
    case (a)
      4'h1, 4'h3, 4'h6: cntMask = 4'h7;
      4'h5:             cntMask = 4'h3;
      4'h8:             cntMask = 4'h3;
      4'hA:             cntMask = 4'h1;
      default:          cntMask = 4'hF;
    endcase
  endfunction

  // Alarm bank holds only minute to day digits
  function automatic logic [3:0] almMask(input logic [3:0] a);
    almMask = (a >= 4'h2 && a <= 4'h8) ? cntMask(a) : 4'h0;
  endfunction

  // Two-stage sync of every pin, edges from the second stage only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinsMeta <= '{selLowN: 1'b1, rdN: 1'b1, wrN: 1'b1, default: '0};
      pins <= '{selLowN: 1'b1, rdN: 1'b1, wrN: 1'b1, default: '0};
      pinsPrev <= '{selLowN: 1'b1, rdN: 1'b1, wrN: 1'b1, default: '0};
    end else if (clkEn) begin
      pinsMeta <= '{selHigh: selHigh, selLowN: selLowN, rdN: rdN, wrN: wrN,
                    addr: nibbleAddress, data: nibbleDataIn,
                    adjust: secondsRoundInput, crystal: crystalInput};
      pins <= pinsMeta;
      pinsPrev <= pins;
    end
  end

  assign selected = pins.selHigh && !pins.selLowN;
  assign wrCommit = (busState == BUS_WRITE) && selected && pins.wrN;

  always_comb begin
    wrCnt = '0;
    if (wrCommit && holdAddr <= `RBC_CNT_LAST) begin
      wrCnt.cntEn = (modeReg[1:0] == 2'b00);
      wrCnt.leapEn = (modeReg[1:0] == 2'b01) && (holdAddr == `RBC_ADDR_LEAP);
      wrCnt.addr = holdAddr;
      wrCnt.data = holdData & (wrCnt.cntEn ? cntMask(holdAddr) : 4'h3);
    end
  end

  rbc_counter_chain u_chain (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .clkEn    (clkEn),
    .secTick  (secTick),
    .adjPulse (adjPulse),
    .mode24   (sel24),
    .wr       (wrCnt),
    .cnt      (cnt),
    .leap     (leap)
  );

  always_comb begin
    next_modeReg = modeReg;
    next_testReg = testReg;
    next_pulseOn = pulseOn;
    next_sel24 = sel24;
    next_alarmReg = alarmReg;
    next_ram = ram;
    next_busState = busState;
    next_holdAddr = holdAddr;
    next_holdData = holdData;
    next_dataOut = 4'h0;
    next_dataOe = 1'b0;
    next_divCnt = divCnt;
    next_secTick = 1'b0;
    next_adjPulse = pins.adjust && !pinsPrev.adjust;
    next_alarmFlag = alarmFlag;
    // Crystal rising edges drive the divider
    if (pins.crystal && !pinsPrev.crystal) begin
      next_divCnt = divCnt + `RBC_DIV_W'(1);
      next_secTick = (divCnt == `RBC_DIV_W'(`RBC_XTAL_DIV - 1)) &&
                     modeReg[`RBC_MODE_TIMER_EN];
    end
    case (busState)
      BUS_IDLE: begin
        if (selected && !pins.rdN) begin
          next_busState = BUS_READ;
        end else if (selected && !pins.wrN) begin
          next_busState = BUS_WRITE;
        end
      end
      BUS_READ: begin
        next_dataOe = 1'b1;
        case (pins.addr)
          `RBC_ADDR_MODE: next_dataOut = modeReg;
          `RBC_ADDR_TEST: next_dataOut = testReg;
          `RBC_ADDR_CTRL: next_dataOut = {pulseOn, 2'b00};
          default: begin
            case (modeReg[1:0])
              2'b00: next_dataOut = cnt[pins.addr] & cntMask(pins.addr);
              2'b01: begin
                if (pins.addr == `RBC_ADDR_SEL24) next_dataOut = {3'b000, sel24};
                else if (pins.addr == `RBC_ADDR_LEAP) next_dataOut = {2'b00, leap};
                else next_dataOut = alarmReg[pins.addr] & almMask(pins.addr);
              end
              2'b10: next_dataOut = ram[pins.addr];
              default: next_dataOut = ram[`RBC_RAM_BANK + pins.addr];
            endcase
          end
        endcase
        if (pins.rdN || !selected) begin
          next_busState = BUS_IDLE;
          next_dataOe = 1'b0;
        end
      end
      BUS_WRITE: begin
        if (!selected) begin
          next_busState = BUS_IDLE;
        end else if (pins.wrN) begin
          next_busState = BUS_IDLE;
        end else begin
          next_holdAddr = pins.addr;
          next_holdData = pins.data;
        end
      end
      default: next_busState = BUS_IDLE;
    endcase
    if (wrCommit) begin
      case (holdAddr)
        `RBC_ADDR_MODE: next_modeReg = holdData;
        `RBC_ADDR_TEST: next_testReg = holdData;
        `RBC_ADDR_CTRL: begin
          next_pulseOn = holdData[`RBC_CTRL_1HZ:`RBC_CTRL_16HZ];
          if (holdData[`RBC_CTRL_TMR_RST]) next_divCnt = '0;
          if (holdData[`RBC_CTRL_ALM_RST]) next_alarmFlag = 1'b0;
        end
        default: begin
          case (modeReg[1:0])
            2'b01: begin
              if (holdAddr == `RBC_ADDR_SEL24) next_sel24 = holdData[0];
              else next_alarmReg[holdAddr] = holdData & almMask(holdAddr);
            end
            2'b10: next_ram[holdAddr] = holdData;
            2'b11: next_ram[`RBC_RAM_BANK + holdAddr] = holdData;
            default: ;
          endcase
        end
      endcase
    end
    // Match at minute start; set wins over a same-cycle clear
    if (secTick && cnt[1:0] == '0 && cnt[8:2] == alarmReg[8:2]) begin
      next_alarmFlag = 1'b1;
    end
    next_alarmOe = (modeReg[`RBC_MODE_ALARM_EN] && alarmFlag) ||
                   (pulseOn[0] && divCnt[`RBC_BIT_16HZ]) ||
                   (pulseOn[1] && divCnt[`RBC_BIT_1HZ]);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      modeReg <= `RBC_MODE_RESET;
      testReg <= 4'h0;
      pulseOn <= 2'b00;
      sel24 <= 1'b0;
      alarmReg <= '0;
      ram <= '0;
      busState <= BUS_IDLE;
      holdAddr <= 4'h0;
      holdData <= 4'h0;
      divCnt <= '0;
      secTick <= 1'b0;
      adjPulse <= 1'b0;
      alarmFlag <= 1'b0;
      nibbleDataOut <= 4'h0;
      nibbleDataOe <= 1'b0;
      crystalOutput <= 1'b1;
      alarmOut <= 1'b0;
      alarmOe <= 1'b0;
    end else if (clkEn) begin
      modeReg <= next_modeReg;
      testReg <= next_testReg;
      pulseOn <= next_pulseOn;
      sel24 <= next_sel24;
      alarmReg <= next_alarmReg;
      ram <= next_ram;
      busState <= next_busState;
      holdAddr <= next_holdAddr;
      holdData <= next_holdData;
      divCnt <= next_divCnt;
      secTick <= next_secTick;
      adjPulse <= next_adjPulse;
      alarmFlag <= next_alarmFlag;
      nibbleDataOut <= next_dataOut;
      nibbleDataOe <= next_dataOe;
      crystalOutput <= ~pins.crystal;
      alarmOut <= 1'b0;
      alarmOe <= next_alarmOe;
    end
  end
endmodule // rbc_core
`default_nettype wire

// >>> rbc_core_properties.sv
// Purpose: Bus and pin properties for rbc_core
// Assumes: Checks stand down while clkEn is low, as all state is frozen
// Notes:   One cycle of slack on read latency
`timescale 1ns/1ps
`default_nettype none
module rbc_core_properties (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       clkEn,
  // Bus
  input wire logic       selHigh,
  input wire logic       selLowN,
  input wire logic       rdN,
  input wire logic       nibbleDataOe,
  // Pins
  input wire logic       crystalInput,
  input wire logic       crystalOutput,
  input wire logic       alarmOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !clkEn);
  sequence s_selRd;
    selHigh && !selLowN && !rdN;
  endsequence
  sequence s_unsel;
    !selHigh || selLowN;
  endsequence
  property p_rdOe;
    s_selRd [*6] |-> nibbleDataOe;
  endproperty
  a_rdOe: assert property (p_rdOe) else $error("read not driven");
  property p_noSelOe;
    s_unsel [*5] |-> !nibbleDataOe;
  endproperty
  a_noSelOe: assert property (p_noSelOe) else $error("drive while unselected");
  property p_rdHighOff;
    rdN [*5] |-> !nibbleDataOe;
  endproperty
  a_rdHighOff: assert property (p_rdHighOff) else $error("drive without read");
  property p_oeStands;
    s_selRd ##0 nibbleDataOe |=> nibbleDataOe;
  endproperty
  a_oeStands: assert property (p_oeStands) else $error("drive dropped early");
  property p_oeRise;
    $rose(nibbleDataOe) |-> $past(!rdN, 3) || $past(!rdN, 4);
  endproperty
  a_oeRise: assert property (p_oeRise) else $error("drive without strobe");
  property p_oeDrop;
    $rose(rdN) |-> ##[1:5] !nibbleDataOe;
  endproperty
  a_oeDrop: assert property (p_oeDrop) else $error("drive held too long");
  property p_alarmOd;
    !alarmOut;
  endproperty
  a_alarmOd: assert property (p_alarmOd) else $error("alarm pin driven high");
  property p_xtalOut;
    (crystalInput == $past(crystalInput)) [*4] |-> crystalOutput != crystalInput;
  endproperty
  a_xtalOut: assert property (p_xtalOut) else $error("crystal output not inverse");
endmodule // rbc_core_properties
bind rbc_core rbc_core_properties chkU (
  .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .selHigh(selHigh), .selLowN(selLowN), .rdN(rdN),
  .nibbleDataOe(nibbleDataOe), .crystalInput(crystalInput),
  .crystalOutput(crystalOutput), .alarmOut(alarmOut));
`default_nettype wire

// >>> rbc_host_model.sv
// Purpose: CPU and power-fail detector side of the nibble bus
// Assumes: sel = {selHigh, selLowN}
// Notes:   Released bus wanders so stale data cannot pass
`timescale 1ns/1ps
`default_nettype none
module rbc_host_model (
  // Clock
  input  wire logic       clk_sys,
  // Bus
  output logic            selHigh,
  output logic            selLowN,
  output logic            rdN,
  output logic            wrN,
  output logic [3:0]      nibbleAddress,
  output logic [3:0]      nibbleDataIn,
  input  wire logic [3:0] nibbleDataOut,
  input  wire logic       nibbleDataOe
);
  logic [3:0] hostData;
  logic       hostOe;
  logic [3:0] floatPat;
  initial begin
    {selHigh, selLowN, rdN, wrN} = 4'hB;
    nibbleAddress = 4'h0;
    hostData = 4'h0;
    hostOe = 1'b0;
    floatPat = 4'h5;
  end
  always @(posedge clk_sys) floatPat <= floatPat + 4'h3;
  assign nibbleDataIn = nibbleDataOe ? nibbleDataOut : (hostOe ? hostData : floatPat);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic busWrite(input logic [1:0] sel, input logic [3:0] a, input logic [3:0] d);
    {selHigh, selLowN} = sel;
    nibbleAddress = a;
    hostData = d;
    hostOe = 1'b1;
    cyc(1);
    wrN = 1'b0;
    cyc(6);
    wrN = 1'b1;
    cyc(4);
    hostOe = 1'b0;
    {selHigh, selLowN} = 2'h2;
    cyc(4);
  endtask
  task automatic busRead(input logic [1:0] sel, input logic [3:0] a,
                         output logic [3:0] d, output logic oe);
    {selHigh, selLowN} = sel;
    nibbleAddress = a;
    cyc(1);
    rdN = 1'b0;
    repeat (7) @(posedge clk_sys);
    d = nibbleDataIn;
    oe = nibbleDataOe;
    #1;
    rdN = 1'b1;
    cyc(4);
    {selHigh, selLowN} = 2'h2;
    cyc(1);
  endtask
endmodule // rbc_host_model
`default_nettype wire

// >>> tb_rbc_core.sv
// Purpose: Self-checking bench for rbc_core
// Assumes: Crystal period of 10 system clocks
// Notes:   Seconds tick is too slow to reach; 16 Hz pulse used instead
`timescale 1ns/1ps
`default_nettype none
`include "rbc_defines.svh"
module tb_rbc_core;
  typedef struct packed {
    logic [1:0] bank;
    logic [3:0] addr;
    logic [3:0] wd;
    logic [3:0] exp;
  } rbc_row_t;
  logic       clk_sys, rst, clkEn, secondsRoundInput, crystalInput;
  logic       selHigh, selLowN, rdN, wrN, nibbleDataOe;
  logic [3:0] nibbleAddress, nibbleDataIn, nibbleDataOut, rdData;
  logic       crystalOutput, alarmOut, alarmOe, rdOe, xtalHold;
  int         err_count, checks, cycles, n, m;
  rbc_row_t   rows [15] = '{
    '{2'h0, 4'h0, 4'h9, 4'h9}, '{2'h0, 4'h1, 4'hF, 4'h7},
    '{2'h0, 4'h5, 4'hF, 4'h3}, '{2'h0, 4'hA, 4'hF, 4'h1},
    '{2'h0, 4'hC, 4'h9, 4'h9}, '{2'h1, 4'h3, 4'hF, 4'h7},
    '{2'h1, 4'h0, 4'hF, 4'h0}, '{2'h1, 4'hA, 4'hF, 4'h1},
    '{2'h1, 4'hB, 4'hF, 4'h3}, '{2'h2, 4'h0, 4'hA, 4'hA},
    '{2'h2, 4'hC, 4'h5, 4'h5}, '{2'h3, 4'hC, 4'h3, 4'h3},
    '{2'h0, 4'hF, 4'h8, 4'h8}, '{2'h0, 4'hF, 4'h3, 4'h0},
    '{2'h3, 4'hE, 4'h5, 4'h5}};
  // Select 24, seconds units, tens, minute units, tens, hour units, tens,
  // then expected minute units, tens, hour units, tens
  logic [3:0] seconds_round_input [6][11] = '{
    '{4'h1, 4'h5, 4'h4, 4'h8, 4'h5, 4'h0, 4'h0, 4'h9, 4'h5, 4'h0, 4'h0},
    '{4'h1, 4'h9, 4'h2, 4'h9, 4'h5, 4'h0, 4'h0, 4'h9, 4'h5, 4'h0, 4'h0},
    '{4'h1, 4'h0, 4'h3, 4'h9, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0},
    '{4'h1, 4'h5, 4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0},
    '{4'h0, 4'h5, 4'h4, 4'h9, 4'h5, 4'h1, 4'h1, 4'h0, 4'h0, 4'h2, 4'h3},
    '{4'h0, 4'h5, 4'h4, 4'h9, 4'h5, 4'h1, 4'h3, 4'h0, 4'h0, 4'h2, 4'h1}};
  rbc_core dut_u (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .selHigh(selHigh),
    .selLowN(selLowN), .rdN(rdN), .wrN(wrN), .nibbleAddress(nibbleAddress),
    .nibbleDataIn(nibbleDataIn), .nibbleDataOut(nibbleDataOut),
    .nibbleDataOe(nibbleDataOe), .secondsRoundInput(secondsRoundInput),
    .crystalInput(crystalInput), .crystalOutput(crystalOutput),
    .alarmOut(alarmOut), .alarmOe(alarmOe));
  rbc_host_model hostU (.clk_sys(clk_sys), .selHigh(selHigh), .selLowN(selLowN),
    .rdN(rdN), .wrN(wrN), .nibbleAddress(nibbleAddress), .nibbleDataIn(nibbleDataIn),
    .nibbleDataOut(nibbleDataOut), .nibbleDataOe(nibbleDataOe));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    crystalInput = 1'b0;
    forever begin
      repeat (5) @(posedge clk_sys);
      #1 crystalInput = ~crystalInput;
    end
  end
  // Whole run needs about 25000 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      $display("ERROR timeout expected done seen %0d cycles", cycles);
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("Counts: checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk4(input string nm, input logic [3:0] e, input logic [3:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic setBank(input logic [1:0] b);
    hostU.busWrite(2'h2, `RBC_ADDR_MODE, {2'h2, b});
  endtask
  task automatic rdChk(input string nm, input logic [3:0] a, input logic [3:0] e);
    hostU.busRead(2'h2, a, rdData, rdOe);
    chk1({nm, " drive"}, 1'b1, rdOe);
    chk4(nm, e, rdData);
  endtask
  initial begin
    {rst, clkEn, secondsRoundInput} = 3'h6;
    repeat (12) @(posedge clk_sys);
    chk1("reset data drive", 1'b0, nibbleDataOe);
    chk1("reset alarm drive", 1'b0, alarmOe);
    #1 rst = 1'b0;
    hostU.cyc(2);
    rdChk("reset mode", `RBC_ADDR_MODE, 4'h8);
    rdChk("reset seconds", 4'h0, 4'h0);
    foreach (rows[i]) begin
      setBank(rows[i].bank);
      hostU.busWrite(2'h2, rows[i].addr, rows[i].wd);
      rdChk("row", rows[i].addr, rows[i].exp);
    end
    // Power-fail and CPU deselect both block writes and reads
    setBank(2'h2);
    hostU.busWrite(2'h2, 4'h3, 4'h6);
    for (int s = 0; s < 4; s++) begin
      if (s == 2) continue;
      hostU.busWrite(s[1:0], 4'h3, 4'h9);
      hostU.busRead(s[1:0], 4'h3, rdData, rdOe);
      chk1("unselected drive", 1'b0, rdOe);
    end
    rdChk("ram kept", 4'h3, 4'h6);
    // Minute carry from adjust also rolls hours in both formats
    foreach (seconds_round_input[i]) begin
      setBank(2'h1);
      hostU.busWrite(2'h2, `RBC_ADDR_SEL24, seconds_round_input[i][0]);
      setBank(2'h0);
      for (int k = 0; k < 6; k++) hostU.busWrite(2'h2, k[3:0], seconds_round_input[i][k+1]);
      secondsRoundInput = 1'b1;
      hostU.cyc(6);
      secondsRoundInput = 1'b0;
      hostU.cyc(6);
      rdChk("adj sec units", 4'h0, 4'h0);
      rdChk("adj sec tens", 4'h1, 4'h0);
      rdChk("adj min units", 4'h2, seconds_round_input[i][7]);
      rdChk("adj min tens", 4'h3, seconds_round_input[i][8]);
      rdChk("adj hour units", 4'h4, seconds_round_input[i][9]);
      rdChk("adj hour tens", 4'h5, seconds_round_input[i][10]);
    end
    // Clock enable low freezes the pin sync, so a write then is lost
    setBank(2'h2);
    clkEn = 1'b0;
    xtalHold = crystalOutput;
    hostU.busWrite(2'h2, 4'h3, 4'hC);
    chk1("frozen crystal out", xtalHold, crystalOutput);
    clkEn = 1'b1;
    hostU.cyc(4);
    rdChk("frozen write", 4'h3, 4'h6);
    // 16 Hz is divider bit 10: 1024 crystal edges of 10 clocks each
    hostU.busWrite(2'h2, `RBC_ADDR_CTRL, 4'h6);
    n = 0;
    while (!alarmOe && n < 15000) begin
      hostU.cyc(1);
      n++;
    end
    chk1("pulse rise window", 1'b1, n > 10150 && n < 10300);
    m = 0;
    while (alarmOe && m < 15000) begin
      hostU.cyc(1);
      m++;
    end
    chk1("pulse high window", 1'b1, m > 10200 && m < 10280);
    hostU.busWrite(2'h2, `RBC_ADDR_CTRL, 4'h0);
    hostU.cyc(2000);
    chk1("pulse off", 1'b0, alarmOe);
    // Mid-run reset returns mode and counters to their reset values
    rst = 1'b1;
    hostU.cyc(3);
    chk1("mid reset drive", 1'b0, nibbleDataOe);
    rst = 1'b0;
    hostU.cyc(2);
    rdChk("mid reset mode", `RBC_ADDR_MODE, 4'h8);
    rdChk("mid reset hour tens", 4'h5, 4'h0);
    tally_and_finish();
  end
endmodule // tb_rbc_core
`default_nettype wire
